// File: hdl/gcl_port.v
/*
 * GPIO port register block with configuration lock and alternate-function
 * selection, an AXI4-Lite slave on aclk/aresetn.
 * Assumes an AXI4-Lite master with at most one write and one read in
 * flight, and pin_input_value already synchronous to aclk.
 */
// Our own choice: the AXI4-Lite register port.
// Contract
// - Lock mask bits 15:0 pick pins frozen by a correct key sequence.
// - After the sequence, locked pin settings stay frozen until reset.
// - A set mask bit freezes that pin's control and alternate settings.
// - Key bit 16 always readable, changed only by the key sequence.
// - Any wrong step abandons the attempt, nothing gets locked.
// - After a successful sequence key reads 1 until reset.
// - Mask bits writable only while key reads 0.
// - With key at 1 the lock register is unmodifiable until reset.
// - Lock register at 0x1C, reset zero, bits 31:17 reserved.
// - Low alternate register 0x20 holds 4-bit selectors for pins 0-7.
// - High alternate register 0x24 holds selectors for pins 8-15.
`timescale 1ns/100ps
`include "gcl_defines.vh"

module gcl_port #(
	parameter NPINS = 16
) (
	input wire aclk,
	input wire aresetn,
	input wire [7:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire [15:0] pin_input_value,
	output wire [31:0] pin_mode_select,
	output wire [15:0] output_type_select,
	output wire [31:0] output_speed_select,
	output wire [31:0] pull_resistor_select,
	output reg [15:0] pin_output_value,
	output wire [31:0] alt_func_select_low,
	output wire [31:0] alt_func_select_high,
	output reg [15:0] pin_lock_mask,
	output reg lock_key
);

	// ======================================================================
	// Write channel capture: address and data taken in either order.
	reg aw_held;
	reg w_held;
	reg [7:0] aw_addr;
	reg [31:0] w_data;
	reg [3:0] w_strb;
	reg [1:0] key_state;
	reg [1:0] next_key_state;
	wire wr_go;
	wire [31:0] bmask;
	wire full_word;
	wire lock_ok;
	reg mapped_w;
	reg mapped_r;
	reg [31:0] rd_val;

	// Ready outputs: a channel refuses while it is held or an answer waits.
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign wr_go = aw_held && w_held && !s_axi_bvalid;

	// Byte strobes widened to a bit mask, and the full-word test.
	assign bmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}},
		{8{w_strb[0]}}};
	assign full_word = (w_strb == 4'hf);

	// Holding registers for address and data until both are present.
	// A channel taken early waits here, so either order is accepted.
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= `GCL_RST_ZERO32;
			w_strb <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end else if (wr_go) begin
				aw_held <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end else if (wr_go) begin
				w_held <= 1'b0;
			end
		end
	end

	// Write address decode; unmapped addresses answer with an error.
	always @* begin
		case ({aw_addr[7:2], 2'b00})
		`GCL_OFS_MODE, `GCL_OFS_OTYPE, `GCL_OFS_OSPEED, `GCL_OFS_PULL,
		`GCL_OFS_INPUT, `GCL_OFS_OUTPUT, `GCL_OFS_SETCLR, `GCL_OFS_LOCK,
		`GCL_OFS_AFLOW, `GCL_OFS_AFHIGH: begin
			mapped_w = 1'b1;
		end
		default: begin
			mapped_w = 1'b0;
		end
		endcase
	end

	// Write response: one cycle after both channels were taken.
	// No new write is taken while the answer waits, so one is in flight.
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `GCL_RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= mapped_w ? `GCL_RESP_OKAY : `GCL_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ======================================================================
	// Per-register write strobes.
	wire lock_wr = wr_go && ({aw_addr[7:2], 2'b00} == `GCL_OFS_LOCK);
	wire mode_wr = wr_go && ({aw_addr[7:2], 2'b00} == `GCL_OFS_MODE);
	wire otype_wr = wr_go && ({aw_addr[7:2], 2'b00} == `GCL_OFS_OTYPE);
	wire speed_wr = wr_go && ({aw_addr[7:2], 2'b00} == `GCL_OFS_OSPEED);
	wire pull_wr = wr_go && ({aw_addr[7:2], 2'b00} == `GCL_OFS_PULL);
	wire out_wr = wr_go && ({aw_addr[7:2], 2'b00} == `GCL_OFS_OUTPUT);
	wire sc_wr = wr_go && ({aw_addr[7:2], 2'b00} == `GCL_OFS_SETCLR);
	wire afl_wr = wr_go && ({aw_addr[7:2], 2'b00} == `GCL_OFS_AFLOW);
	wire afh_wr = wr_go && ({aw_addr[7:2], 2'b00} == `GCL_OFS_AFHIGH);

	// Key bit of the captured write and its mask against the stored mask.
	wire key_bit = w_data[`GCL_KEY_BIT];
	wire mask_same = (w_data[15:0] == pin_lock_mask);

	// ======================================================================
	// Key sequence tracker: 1, 0, 1 with an unchanged mask, full words only.
	// Reads leave it alone; once the key is set it is no longer used.
	always @* begin
		next_key_state = key_state;
		if (lock_wr && !lock_key) begin
			if (!full_word) begin
				next_key_state = `GCL_KS_IDLE;
			end else begin
				case (key_state)
				`GCL_KS_IDLE: begin
					next_key_state = key_bit ? `GCL_KS_ONE : `GCL_KS_IDLE;
				end
				`GCL_KS_ONE: begin
					// A 0 with a changed mask aborts; a repeated 1 counts as a new first write.
					if (!key_bit && mask_same) begin
						next_key_state = `GCL_KS_ZERO;
					end else begin
						next_key_state = key_bit ? `GCL_KS_ONE : `GCL_KS_IDLE;
					end
				end
				`GCL_KS_ZERO: begin
					next_key_state = `GCL_KS_IDLE;
				end
				default: begin
					next_key_state = `GCL_KS_IDLE;
				end
				endcase
			end
		end
	end

	// The third write arms the key when it carries 1 and the same mask.
	assign lock_ok = lock_wr && !lock_key && full_word &&
		key_state == `GCL_KS_ZERO && key_bit && mask_same;

	// Lock register: mask writable only while the key is clear.
	// The key has no clear path but reset, so the lock holds until reset.
	always @(posedge aclk) begin
		if (!aresetn) begin
			key_state <= `GCL_KS_IDLE;
			lock_key <= 1'b0;
			pin_lock_mask <= `GCL_RST_ZERO16;
		end else begin
			key_state <= next_key_state;
			if (lock_ok) begin
				lock_key <= 1'b1;
			end
			if (lock_wr && !lock_key) begin
				// Key clear: the mask takes the written bytes under the strobes.
				pin_lock_mask <= (pin_lock_mask & ~bmask[15:0]) |
					(w_data[15:0] & bmask[15:0]);
			end
		end
	end

	// ======================================================================
	// Per-pin configuration fields, each frozen when its pin is locked.
	wire [NPINS-1:0] pin_frozen = pin_lock_mask & {NPINS{lock_key}};

	// One lock-gated field per pin in every control register.
	genvar g;
	generate
		for (g = 0; g < NPINS; g = g + 1) begin : pin
			localparam integer HB = (g % 8) * 4;
			gcl_field_reg #(.W(2), .RST(2'b11)) u_mode (
				.aclk(aclk), .aresetn(aresetn), .wr(mode_wr),
				.locked(pin_frozen[g]),
				.wdata(w_data[2*g+1:2*g]), .wmask(bmask[2*g+1:2*g]),
				.q(pin_mode_select[2*g+1:2*g]));
			gcl_field_reg #(.W(1), .RST(1'b0)) u_otype (
				.aclk(aclk), .aresetn(aresetn), .wr(otype_wr),
				.locked(pin_frozen[g]),
				.wdata(w_data[g]), .wmask(bmask[g]),
				.q(output_type_select[g]));
			gcl_field_reg #(.W(2), .RST(2'b00)) u_speed (
				.aclk(aclk), .aresetn(aresetn), .wr(speed_wr),
				.locked(pin_frozen[g]),
				.wdata(w_data[2*g+1:2*g]), .wmask(bmask[2*g+1:2*g]),
				.q(output_speed_select[2*g+1:2*g]));
			gcl_field_reg #(.W(2), .RST(2'b00)) u_pull (
				.aclk(aclk), .aresetn(aresetn), .wr(pull_wr),
				.locked(pin_frozen[g]),
				.wdata(w_data[2*g+1:2*g]), .wmask(bmask[2*g+1:2*g]),
				.q(pull_resistor_select[2*g+1:2*g]));
			if (g < 8) begin : lo
				gcl_field_reg #(.W(`GCL_AF_W), .RST(4'h0)) u_af (
					.aclk(aclk), .aresetn(aresetn), .wr(afl_wr),
					.locked(pin_frozen[g]),
					.wdata(w_data[HB+3:HB]), .wmask(bmask[HB+3:HB]),
					.q(alt_func_select_low[HB+3:HB]));
			end else begin : hi
				gcl_field_reg #(.W(`GCL_AF_W), .RST(4'h0)) u_af (
					.aclk(aclk), .aresetn(aresetn), .wr(afh_wr),
					.locked(pin_frozen[g]),
					.wdata(w_data[HB+3:HB]), .wmask(bmask[HB+3:HB]),
					.q(alt_func_select_high[HB+3:HB]));
			end
		end
	endgenerate

	// ======================================================================
	// Output data with atomic set/clear; set wins over clear.
	// Output data is not configuration, so it never locks.
	always @(posedge aclk) begin
		if (!aresetn) begin
			pin_output_value <= `GCL_RST_ZERO16;
		end else if (out_wr) begin
			pin_output_value <= (pin_output_value & ~bmask[15:0]) |
				(w_data[15:0] & bmask[15:0]);
		end else if (sc_wr) begin
			pin_output_value <= (pin_output_value &
				~(w_data[31:16] & bmask[31:16])) |
				(w_data[15:0] & bmask[15:0]);
		end
	end

	// ======================================================================
	// Read path: one-cycle latency, unmapped reads answer with an error.
	always @* begin
		mapped_r = 1'b1;
		case ({s_axi_araddr[7:2], 2'b00})
		`GCL_OFS_MODE: rd_val = pin_mode_select;
		`GCL_OFS_OTYPE: rd_val = {16'h0000, output_type_select};
		`GCL_OFS_OSPEED: rd_val = output_speed_select;
		`GCL_OFS_PULL: rd_val = pull_resistor_select;
		`GCL_OFS_INPUT: rd_val = {16'h0000, pin_input_value};
		`GCL_OFS_OUTPUT: rd_val = {16'h0000, pin_output_value};
		`GCL_OFS_SETCLR: rd_val = `GCL_RST_ZERO32;
		`GCL_OFS_LOCK: rd_val = {15'h0000, lock_key, pin_lock_mask};
		`GCL_OFS_AFLOW: rd_val = alt_func_select_low;
		`GCL_OFS_AFHIGH: rd_val = alt_func_select_high;
		default: begin
			rd_val = `GCL_RST_ZERO32;
			mapped_r = 1'b0;
		end
		endcase
	end

	// Read data register, held until the master takes it.
	// Data is caught at the accepting edge, so it cannot tear later.
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= `GCL_RST_ZERO32;
			s_axi_rresp <= `GCL_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_val;
			s_axi_rresp <= mapped_r ? `GCL_RESP_OKAY : `GCL_RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule

// File: hdl/gcl_defines.vh
/*
 * Constants for the GPIO port configuration lock and alternate-function
 * block: register byte offsets, field positions, reset values and the
 * states of the lock key sequence tracker.
 * Assumes inclusion by bare name from the design files of this block.
 */
`ifndef GCL_DEFINES_VH
`define GCL_DEFINES_VH

// ==========================================================================
// Register byte offsets
`define GCL_OFS_MODE 8'h00
`define GCL_OFS_OTYPE 8'h04
`define GCL_OFS_OSPEED 8'h08
`define GCL_OFS_PULL 8'h0c
`define GCL_OFS_INPUT 8'h10
`define GCL_OFS_OUTPUT 8'h14
`define GCL_OFS_SETCLR 8'h18
`define GCL_OFS_LOCK 8'h1c
`define GCL_OFS_AFLOW 8'h20
`define GCL_OFS_AFHIGH 8'h24

// ==========================================================================
// Field positions and widths
`define GCL_KEY_BIT 16
`define GCL_NPINS 16
`define GCL_AF_W 4

// ==========================================================================
// Reset values
`define GCL_RST_MODE 32'hffff_ffff
`define GCL_RST_ZERO32 32'h0000_0000
`define GCL_RST_ZERO16 16'h0000

// ==========================================================================
// Key sequence tracker states
`define GCL_KS_IDLE 2'b00
`define GCL_KS_ONE 2'b01
`define GCL_KS_ZERO 2'b10

// ==========================================================================
// AXI responses
`define GCL_RESP_OKAY 2'b00
`define GCL_RESP_SLVERR 2'b10

`endif

// File: hdl/gcl_field_reg.v
/*
 * One per-pin configuration field with a lock gate: the field is loaded
 * from the bus under byte strobes only while its pin is not locked.
 * Assumes a synchronous active-low reset and a single clock aclk.
 */
`timescale 1ns/100ps

module gcl_field_reg #(
	parameter W = 2,
	parameter [W-1:0] RST = {W{1'b0}}
) (
	input wire aclk,
	input wire aresetn,
	input wire wr,
	input wire locked,
	input wire [W-1:0] wdata,
	input wire [W-1:0] wmask,
	output reg [W-1:0] q
);

	// ======================================================================
	// Field storage: a locked pin ignores every write.
	always @(posedge aclk) begin
		if (!aresetn) begin
			q <= RST;
		end else if (wr && !locked) begin
			q <= (q & ~wmask) | (wdata & wmask);
		end
	end

endmodule

// File: bench/gcl_port_props.sv
/* Port checker for gcl_port: lock key, lock mask and frozen fields.
   Assumes one clock aclk and a synchronous active-low aresetn. */
`timescale 1ns/100ps
// ====================
// Checker
module gcl_port_props (
	input logic aclk,
	input logic aresetn,
	input logic [7:0] s_axi_araddr,
	input logic s_axi_arvalid,
	input logic s_axi_arready,
	input logic s_axi_bvalid,
	input logic [1:0] s_axi_bresp,
	input logic s_axi_rvalid,
	input logic [31:0] s_axi_rdata,
	input logic [31:0] pin_mode_select,
	input logic [31:0] alt_func_select_low,
	input logic [31:0] alt_func_select_high,
	input logic [15:0] pin_lock_mask,
	input logic lock_key
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic rd_lock;
	// Notes whether the read being answered targets the lock register.
	always @(posedge aclk) begin
		if (s_axi_arvalid && s_axi_arready) begin
			rd_lock <= s_axi_araddr[7:2] == 6'h07;
		end
	end
	// Key bit and mask behaviour.
	property p_key_sticky; lock_key |=> lock_key; endproperty
	a_key_sticky: assert property (p_key_sticky)
		else $error("Lock key cleared.");
	property p_lock_frozen; lock_key |=> $stable(pin_lock_mask); endproperty
	a_lock_frozen: assert property (p_lock_frozen)
		else $error("Mask changed while key set.");
	property p_key_by_write; $rose(lock_key) |-> $rose(s_axi_bvalid); endproperty
	a_key_by_write: assert property (p_key_by_write)
		else $error("Key set outside a write.");
	property p_mask_by_write;
		$past(aresetn) && $changed(pin_lock_mask) |->
			!$past(lock_key) && $rose(s_axi_bvalid);
	endproperty
	a_mask_by_write: assert property (p_mask_by_write)
		else $error("Mask changed without a write.");
	property p_lock_read;
		$rose(s_axi_rvalid) && rd_lock |->
			s_axi_rdata == {15'h0000, lock_key, pin_lock_mask};
	endproperty
	a_lock_read: assert property (p_lock_read)
		else $error("Lock register read wrong.");
	// Fields of locked pins 0 and 8 hold still.
	property p_afl_frozen;
		lock_key && pin_lock_mask[0] |=> $stable(alt_func_select_low[3:0]);
	endproperty
	a_afl_frozen: assert property (p_afl_frozen)
		else $error("Locked low selector changed.");
	property p_afh_frozen;
		lock_key && pin_lock_mask[8] |=> $stable(alt_func_select_high[3:0]);
	endproperty
	a_afh_frozen: assert property (p_afh_frozen)
		else $error("Locked high selector changed.");
	property p_mode_frozen;
		lock_key && pin_lock_mask[8] |=> $stable(pin_mode_select[17:16]);
	endproperty
	a_mode_frozen: assert property (p_mode_frozen)
		else $error("Locked mode field changed.");
	// Main scenarios reached.
	c_armed: cover property ($rose(lock_key));
	c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
	c_lock_read: cover property ($rose(s_axi_rvalid) && rd_lock);
endmodule
// ====================
// Attachment
bind gcl_port gcl_port_props u_props (.aclk, .aresetn, .s_axi_araddr,
	.s_axi_arvalid, .s_axi_arready, .s_axi_bvalid, .s_axi_bresp,
	.s_axi_rvalid, .s_axi_rdata, .pin_mode_select, .alt_func_select_low,
	.alt_func_select_high, .pin_lock_mask, .lock_key);

// File: bench/gcl_port_tb.sv
/* Self-checking bench for gcl_port over AXI4-Lite: register map,
   selectors and the lock key sequence.
   Assumes the design and the checker are compiled first. */
`timescale 1ns/100ps
// ====================
// Bench
module gcl_port_tb;
	logic aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0;
	logic s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
	logic s_axi_rready = 1'h0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic [15:0] pin_input_value = 16'h5a3c;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	wire s_axi_rvalid, lock_key;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata, alt_func_select_low, alt_func_select_high;
	wire [15:0] pin_lock_mask, pin_output_value, output_type_select;
	wire [31:0] pin_mode_select, output_speed_select, pull_resistor_select;
	integer mismatches = 0, checked = 0;
	// Clock of 100 MHz.
	always #5 aclk = ~aclk;
	gcl_port u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0),
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .pin_input_value, .pin_mode_select,
		.output_type_select, .output_speed_select,
		.pull_resistor_select, .pin_output_value, .alt_func_select_low,
		.alt_func_select_high, .pin_lock_mask, .lock_key);
	// Compares one value and counts it.
	task chk(input [31:0] g, input [31:0] e);
		begin
			checked = checked + 1;
			if (g !== e) begin
				mismatches = mismatches + 1;
				$display("Error at %0t: got %h, expected %h", $time, g, e);
			end
		end
	endtask
	// Prints the verdict and ends the run.
	task tally_and_finish;
		begin
			if (mismatches == 0 && checked > 0) $display("[ PASS ]");
			else $display("[ FAIL ]");
			$finish;
		end
	endtask
	// Writes one word; each channel drops when taken, then the answer.
	task wr(input [7:0] a, input [31:0] d, input [3:0] s, input [1:0] er);
		begin
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			s_axi_wstrb <= s;
			s_axi_awvalid <= 1'h1;
			s_axi_wvalid <= 1'h1;
			s_axi_bready <= 1'h1;
			do begin
				@(posedge aclk);
				if (s_axi_awready) s_axi_awvalid <= 1'h0;
				if (s_axi_wready) s_axi_wvalid <= 1'h0;
			end while (s_axi_bvalid !== 1'h1);
			s_axi_bready <= 1'h0;
			chk({30'h0, s_axi_bresp}, {30'h0, er});
			@(posedge aclk);
		end
	endtask
	// Reads one word and checks the response code, and the data when OKAY is expected.
	task rd(input [7:0] a, input [31:0] e, input [1:0] er);
		begin
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'h1;
			s_axi_rready <= 1'h1;
			do begin
				@(posedge aclk);
				if (s_axi_arready) s_axi_arvalid <= 1'h0;
			end while (s_axi_rvalid !== 1'h1);
			s_axi_rready <= 1'h0;
			if (er == 2'h0) chk(s_axi_rdata, e);
			chk({30'h0, s_axi_rresp}, {30'h0, er});
			@(posedge aclk);
		end
	endtask
	// Three key writes with masks m1..m3, the last with strobes s.
	task seq(input [15:0] m1, input [15:0] m2, input [15:0] m3,
		input [3:0] s);
		begin
			wr(8'h1c, {16'h0001, m1}, 4'hf, 2'h0);
			wr(8'h1c, {16'h0000, m2}, 4'hf, 2'h0);
			wr(8'h1c, {16'h0001, m3}, s, 2'h0);
		end
	endtask
	// Reset contents, input pins and an unmapped place.
	task reset_values;
		begin
			rd(8'h1c, 32'h0000_0000, 2'h0);
			rd(8'h20, 32'h0000_0000, 2'h0);
			rd(8'h24, 32'h0000_0000, 2'h0);
			rd(8'h10, 32'h0000_5a3c, 2'h0);
			rd(8'h28, 32'h0000_0000, 2'h2);
			wr(8'h28, 32'h0000_0001, 4'hf, 2'h2);
		end
	endtask
	// Every selector code on the low and high pins.
	task alt_codes;
		begin
			wr(8'h20, 32'h7654_3210, 4'hf, 2'h0);
			wr(8'h24, 32'hfedc_ba98, 4'hf, 2'h0);
			rd(8'h20, 32'h7654_3210, 2'h0);
			rd(8'h24, 32'hfedc_ba98, 2'h0);
			chk(alt_func_select_high, 32'hfedc_ba98);
		end
	endtask
	// Plain write, changed mask and partial word leave the port unlocked.
	task broken_seqs;
		begin
			wr(8'h1c, 32'hfffe_00a5, 4'hf, 2'h0);
			rd(8'h1c, 32'h0000_00a5, 2'h0);
			seq(16'h0101, 16'h0202, 16'h0202, 4'hf);
			rd(8'h1c, 32'h0000_0202, 2'h0);
			seq(16'h0101, 16'h0101, 16'h0101, 4'h7);
			rd(8'h1c, 32'h0000_0101, 2'h0);
		end
	endtask
	// Locks pins 0 and 8, then tries to change them and the lock.
	task lock_port;
		begin
			seq(16'h0101, 16'h0101, 16'h0101, 4'hf);
			rd(8'h1c, 32'h0001_0101, 2'h0);
			wr(8'h1c, 32'h0000_ffff, 4'hf, 2'h0);
			rd(8'h1c, 32'h0001_0101, 2'h0);
			wr(8'h20, 32'hffff_ffff, 4'hf, 2'h0);
			rd(8'h20, 32'hffff_fff0, 2'h0);
			wr(8'h24, 32'h0000_0000, 4'hf, 2'h0);
			rd(8'h24, 32'h0000_0008, 2'h0);
			wr(8'h00, 32'h0000_0000, 4'hf, 2'h0);
			rd(8'h00, 32'h0003_0003, 2'h0);
			chk({16'h0000, pin_lock_mask}, 32'h0000_0101);
		end
	endtask
	// Other control fields of locked pins 0 and 8 hold; output data does not.
	task locked_controls;
		begin
			wr(8'h04, 32'h0000_ffff, 4'hf, 2'h0);
			rd(8'h04, 32'h0000_fefe, 2'h0);
			wr(8'h08, 32'hffff_ffff, 4'hf, 2'h0);
			rd(8'h08, 32'hfffc_fffc, 2'h0);
			wr(8'h0c, 32'hffff_ffff, 4'hf, 2'h0);
			rd(8'h0c, 32'hfffc_fffc, 2'h0);
			chk({16'h0000, output_type_select}, 32'h0000_fefe);
			chk(output_speed_select, 32'hfffc_fffc);
			chk(pull_resistor_select, 32'hfffc_fffc);
			chk(pin_mode_select, 32'h0003_0003);
			wr(8'h14, 32'h0000_ffff, 4'hf, 2'h0);
			wr(8'h18, 32'h00ff_0f0f, 4'hf, 2'h0);
			rd(8'h14, 32'h0000_ff0f, 2'h0);
			rd(8'h18, 32'h0000_0000, 2'h0);
			chk({16'h0000, pin_output_value}, 32'h0000_ff0f);
		end
	endtask
	// A second reset in mid-run clears the lock and frees the pins.
	task reset_unlocks;
		begin
			aresetn <= 1'h0;
			repeat (2) @(posedge aclk);
			aresetn <= 1'h1;
			@(posedge aclk);
			rd(8'h1c, 32'h0000_0000, 2'h0);
			chk({31'h0, lock_key}, 32'h0000_0000);
			rd(8'h00, 32'hffff_ffff, 2'h0);
			wr(8'h20, 32'h0000_0005, 4'hf, 2'h0);
			rd(8'h20, 32'h0000_0005, 2'h0);
		end
	endtask
	// Main sequence after a reset of 16 cycles.
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		reset_values;
		alt_codes;
		broken_seqs;
		lock_port;
		locked_controls;
		reset_unlocks;
		tally_and_finish;
	end
	// Cuts a hang short.
	initial begin
		repeat (3000) @(posedge aclk);
		mismatches = mismatches + 1;
		tally_and_finish;
	end
endmodule
